// *** hw/mq_reset_pkg.sv ***
// Purpose: Shared constants and types for the multi-queue reset controller
// Assumes: One 250 MHz clock, AHB-Lite register access, 32-bit data
// Notes: Register offsets are byte addresses of aligned words
package mq_reset_pkg;

    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_STRAPS = 8'h08;
    localparam logic [7:0] ADDR_OFFSET = 8'h0C;
    localparam logic [7:0] ADDR_EMPTY = 8'h10;

    localparam int CTRL_SERIAL_DONE_BIT = 0;
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_TRAFFIC_BIT = 2;
    localparam int STAT_DEFAULT_BIT = 3;
    localparam int STAT_DONE_BIT = 4;
    localparam int OFFSET_FULL_LSB = 16;

    localparam logic [15:0] OFFSET_LOW = 16'h0008;
    localparam logic [15:0] OFFSET_HIGH = 16'h0080;
    localparam logic [15:0] OFFSET_RESET = 16'h0000;

    localparam int DEFAULT_LOAD_CYCLES = 32;
    localparam logic [1:0] SELECT_HOLD_CYCLES = 2'h2;

    localparam logic [1:0] HTRANS_IDLE = 2'h0;
    localparam logic HRESP_OKAY = 1'b0;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

    typedef struct packed {
        logic packetSelect;
        logic flagBusSelect;
        logic inputWidthSel;
        logic outputWidthSel;
        logic busMatchSel;
        logic leadDeviceSel;
        logic [2:0] deviceIndex;
        logic programSourceSel;
        logic thresholdDefaultSel;
    } strap_cfg_t;

    localparam strap_cfg_t STRAP_RESET = '0;

    typedef enum logic [1:0] {
        CFG_RESET,
        CFG_WAIT_SERIAL,
        CFG_DEFAULT_LOAD,
        CFG_READY
    } cfg_state_t;

endpackage

// *** hw/mq_reset_control.sv ***
// Purpose: Master and partial reset control of a multi-queue FIFO device
// Assumes: Pins sampled synchronously to clk; AHB-Lite slave, zero wait states
// Notes: Configuration is serial (software write) or default (load counter)
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Master reset pin low then high resets device
// - Master reset clears config state, offsets, empty flags and traffic; ptrClearQueue keeps its value
// - Straps captured during master reset
// - No queue traffic until configuration completes
// - Partial reset clears one queue's pointers
// - Partial reset leaves configuration untouched
// - Source strap low serial, high default only
// - Default offsets 8 or 128 by strap
// - Packet strap only captured and read back, no packet mode logic
module mq_reset_control
    import mq_reset_pkg::*;
#(
    parameter int NUM_QUEUES = 32,
    parameter int LOAD_CYCLES = DEFAULT_LOAD_CYCLES,
    localparam int QW = (NUM_QUEUES > 1) ? $clog2(NUM_QUEUES) : 1
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic masterResetN,
    input wire logic queuePointerClearN,
    input wire strap_cfg_t straps,
    input wire logic [QW-1:0] writeQueueSel,
    input wire logic [QW-1:0] readQueueSel,
    input wire logic writeEnable,
    output logic trafficEnable,
    output logic configDone,
    output strap_cfg_t cfgActive,
    output logic [15:0] almostEmptyOffset,
    output logic [15:0] almostFullOffset,
    output logic ptrClearPulse,
    output logic [QW-1:0] ptrClearQueue,
    output logic [NUM_QUEUES-1:0] queueEmpty
);

    if (NUM_QUEUES < 1 || NUM_QUEUES > 32) begin : g_bad_queues
        $error("NUM_QUEUES must be 1 to 32");
    end
    if (LOAD_CYCLES < 1 || LOAD_CYCLES > 65535) begin : g_bad_load
        $error("LOAD_CYCLES must be 1 to 65535");
    end

    localparam logic [15:0] LOAD_LAST = 16'(LOAD_CYCLES - 1);
    localparam logic [NUM_QUEUES-1:0] ALL_EMPTY = '1;

    cfg_state_t state_ff;
    strap_cfg_t strap_ff;
    logic [15:0] loadCnt_ff;
    logic [15:0] aeOffset_ff;
    logic [15:0] afOffset_ff;
    logic [QW-1:0] wrSelPrev_ff;
    logic [QW-1:0] rdSelPrev_ff;
    logic [1:0] wrHold_ff;
    logic [1:0] rdHold_ff;
    logic prsPrev_ff;
    logic clearPulse_ff;
    logic [QW-1:0] clearQueue_ff;
    logic [NUM_QUEUES-1:0] empty_ff;
    logic traffic_ff;
    logic done_ff;
    logic wrPend_ff;
    logic [7:0] wrAddr_ff;
    logic [31:0] rdata_ff;

    logic mrsActive;
    logic addrPhase;
    logic serialDoneWr;
    logic offsetWr;
    logic prsFall;
    logic prsAccept;
    logic nxt_traffic;
    logic [31:0] readMux;

    ////////////////////////////////////////////////////////////////////////
    // Master reset and configuration sequencing

    assign mrsActive = !masterResetN;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            strap_ff <= STRAP_RESET;
        end else if (mrsActive) begin
            strap_ff <= straps;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= CFG_RESET;
        end else if (mrsActive) begin
            state_ff <= CFG_RESET;
        end else begin
            case (state_ff)
                CFG_RESET: begin
                    if (strap_ff.programSourceSel) begin
                        state_ff <= CFG_DEFAULT_LOAD;
                    end else begin
                        state_ff <= CFG_WAIT_SERIAL;
                    end
                end
                CFG_WAIT_SERIAL: begin
                    if (serialDoneWr) begin
                        state_ff <= CFG_READY;
                    end
                end
                CFG_DEFAULT_LOAD: begin
                    if (loadCnt_ff == LOAD_LAST) begin
                        state_ff <= CFG_READY;
                    end
                end
                CFG_READY: begin
                    state_ff <= CFG_READY;
                end
                default: begin
                    state_ff <= CFG_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            loadCnt_ff <= '0;
        end else if (state_ff != CFG_DEFAULT_LOAD) begin
            loadCnt_ff <= '0;
        end else begin
            loadCnt_ff <= loadCnt_ff + 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            aeOffset_ff <= OFFSET_RESET;
            afOffset_ff <= OFFSET_RESET;
        end else if (mrsActive) begin
            aeOffset_ff <= OFFSET_RESET;
            afOffset_ff <= OFFSET_RESET;
        end else if (state_ff == CFG_RESET && strap_ff.programSourceSel) begin
            aeOffset_ff <= strap_ff.thresholdDefaultSel ? OFFSET_HIGH : OFFSET_LOW;
            afOffset_ff <= strap_ff.thresholdDefaultSel ? OFFSET_HIGH : OFFSET_LOW;
        end else if (offsetWr) begin
            aeOffset_ff <= hwdata[OFFSET_FULL_LSB-1:0];
            afOffset_ff <= hwdata[31:OFFSET_FULL_LSB];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Partial reset of one queue

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wrSelPrev_ff <= '0;
            rdSelPrev_ff <= '0;
            wrHold_ff <= '0;
            rdHold_ff <= '0;
        end else begin
            wrSelPrev_ff <= writeQueueSel;
            rdSelPrev_ff <= readQueueSel;
            if (writeQueueSel != wrSelPrev_ff) begin
                wrHold_ff <= 2'h1;
            end else if (wrHold_ff != SELECT_HOLD_CYCLES) begin
                wrHold_ff <= wrHold_ff + 2'h1;
            end
            if (readQueueSel != rdSelPrev_ff) begin
                rdHold_ff <= 2'h1;
            end else if (rdHold_ff != SELECT_HOLD_CYCLES) begin
                rdHold_ff <= rdHold_ff + 2'h1;
            end
        end
    end

    assign prsFall = prsPrev_ff && !queuePointerClearN;
    assign prsAccept = prsFall && (state_ff == CFG_READY) && !mrsActive
        && (wrHold_ff == SELECT_HOLD_CYCLES) && (rdHold_ff == SELECT_HOLD_CYCLES)
        && (writeQueueSel == wrSelPrev_ff) && (readQueueSel == rdSelPrev_ff)
        && (writeQueueSel == readQueueSel);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prsPrev_ff <= 1'b1;
            clearPulse_ff <= 1'b0;
            clearQueue_ff <= '0;
        end else begin
            prsPrev_ff <= queuePointerClearN;
            clearPulse_ff <= prsAccept;
            if (prsAccept) begin
                clearQueue_ff <= writeQueueSel;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            empty_ff <= ALL_EMPTY;
        end else if (mrsActive) begin
            empty_ff <= ALL_EMPTY;
        end else begin
            for (int q = 0; q < NUM_QUEUES; q++) begin
                if (prsAccept && writeQueueSel == QW'(q)) begin
                    empty_ff[q] <= 1'b1;
                end else if (traffic_ff && writeEnable && writeQueueSel == QW'(q)) begin
                    empty_ff[q] <= 1'b0;
                end
            end
        end
    end

    // Traffic blocked until configured and while either reset is low
    assign nxt_traffic = (state_ff == CFG_READY) && !mrsActive
        && queuePointerClearN && !prsFall;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            traffic_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            traffic_ff <= nxt_traffic;
            done_ff <= (state_ff == CFG_READY) && !mrsActive;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite register slave

    assign addrPhase = hsel && hready && htrans[1];
    assign serialDoneWr = wrPend_ff && (wrAddr_ff == ADDR_CTRL)
        && hwdata[CTRL_SERIAL_DONE_BIT] && (state_ff == CFG_WAIT_SERIAL) && !mrsActive;
    assign offsetWr = wrPend_ff && (wrAddr_ff == ADDR_OFFSET)
        && (state_ff == CFG_WAIT_SERIAL);

    always_comb begin
        readMux = RDATA_ZERO;
        case (haddr[7:0])
            ADDR_CTRL: begin
                readMux = RDATA_ZERO;
            end
            ADDR_STATUS: begin
                readMux[STAT_STATE_LSB +: 2] = state_ff;
                readMux[STAT_TRAFFIC_BIT] = traffic_ff;
                readMux[STAT_DEFAULT_BIT] = strap_ff.programSourceSel;
                readMux[STAT_DONE_BIT] = done_ff;
            end
            ADDR_STRAPS: begin
                readMux[$bits(strap_cfg_t)-1:0] = strap_ff;
            end
            ADDR_OFFSET: begin
                readMux = {afOffset_ff, aeOffset_ff};
            end
            ADDR_EMPTY: begin
                readMux[NUM_QUEUES-1:0] = empty_ff;
            end
            default: begin
                readMux = RDATA_ZERO;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wrPend_ff <= 1'b0;
            wrAddr_ff <= '0;
            rdata_ff <= RDATA_ZERO;
        end else begin
            if (hready) begin
                wrPend_ff <= addrPhase && hwrite;
            end
            if (addrPhase) begin
                wrAddr_ff <= haddr[7:0];
            end
            if (addrPhase && !hwrite) begin
                rdata_ff <= readMux;
            end
        end
    end

    assign hrdata = rdata_ff;
    assign hreadyout = 1'b1;
    assign hresp = HRESP_OKAY;
    assign trafficEnable = traffic_ff;
    assign configDone = done_ff;
    assign cfgActive = strap_ff;
    assign almostEmptyOffset = aeOffset_ff;
    assign almostFullOffset = afOffset_ff;
    assign ptrClearPulse = clearPulse_ff;
    assign ptrClearQueue = clearQueue_ff;
    assign queueEmpty = empty_ff;

    logic unusedBits;
    assign unusedBits = ^{haddr[31:8], hsize, htrans[0]};

endmodule
`default_nettype wire

// *** testbench/mq_reset_chk.sv ***
// Purpose: Concurrent checks on the reset controller ports
// Assumes: Single clk domain, nrst async active low
// Notes: Attached by bind below the module
`timescale 1ns/1ps
`default_nettype none
module mq_reset_chk
    import mq_reset_pkg::*;
#(
    parameter int NUM_QUEUES = 32,
    parameter int LOAD_CYCLES = DEFAULT_LOAD_CYCLES,
    localparam int QW = (NUM_QUEUES > 1) ? $clog2(NUM_QUEUES) : 1
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic masterResetN,
    input wire logic queuePointerClearN,
    input wire strap_cfg_t straps,
    input wire logic [QW-1:0] writeQueueSel,
    input wire logic [QW-1:0] readQueueSel,
    input wire logic trafficEnable,
    input wire logic configDone,
    input wire strap_cfg_t cfgActive,
    input wire logic [15:0] almostEmptyOffset,
    input wire logic [15:0] almostFullOffset,
    input wire logic ptrClearPulse,
    input wire logic [QW-1:0] ptrClearQueue,
    input wire logic [NUM_QUEUES-1:0] queueEmpty
);
    localparam int LO = LOAD_CYCLES;
    localparam int HI = LOAD_CYCLES + 3;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////////////////////////////
    sequence serialStart;
        $rose(masterResetN) && !cfgActive.programSourceSel;
    endsequence
    sequence defaultStart;
        $rose(masterResetN) && cfgActive.programSourceSel;
    endsequence
    sequence clearReq;
        $fell(queuePointerClearN) && configDone && masterResetN
            && writeQueueSel == readQueueSel && $stable(writeQueueSel)
            && $past(writeQueueSel, 2) == writeQueueSel && $stable(readQueueSel);
    endsequence
    ////////////////////////////////////////////////////////////////
    a_mrst_clears: assert property (!masterResetN |=> !trafficEnable && !configDone
        && almostEmptyOffset == OFFSET_RESET && almostFullOffset == OFFSET_RESET
        && queueEmpty == {NUM_QUEUES{1'b1}}) else $error("master reset left state");
    a_strap_capture: assert property (!masterResetN |=> cfgActive == $past(straps))
        else $error("straps not captured");
    a_no_traffic: assert property (trafficEnable |-> configDone)
        else $error("traffic before configuration");
    a_serial_wait: assert property (serialStart |=> !configDone [*8])
        else $error("serial mode finished alone");
    a_default_offset: assert property (defaultStart |=> almostEmptyOffset ==
        (cfgActive.thresholdDefaultSel ? OFFSET_HIGH : OFFSET_LOW)
        && almostFullOffset == almostEmptyOffset) else $error("default offset wrong");
    a_default_done: assert property (defaultStart |-> ##[LO:HI] $rose(configDone))
        else $error("default load not done");
    a_clear_pulse: assert property (clearReq |=> ptrClearPulse && !trafficEnable
        && ptrClearQueue == $past(writeQueueSel) && queueEmpty[$past(writeQueueSel)])
        else $error("partial reset not applied");
    a_pulse_cause: assert property (ptrClearPulse |-> !$past(queuePointerClearN)
        && $past(queuePointerClearN, 2) && !$past(ptrClearPulse))
        else $error("clear pulse without cause");
    a_cfg_kept: assert property (ptrClearPulse |-> $stable(cfgActive) && configDone
        && $stable(almostEmptyOffset) && $stable(almostFullOffset))
        else $error("partial reset changed setup");
endmodule
bind mq_reset_control mq_reset_chk #(.NUM_QUEUES(NUM_QUEUES), .LOAD_CYCLES(LOAD_CYCLES)) chk (
    .clk, .nrst, .masterResetN, .queuePointerClearN, .straps, .writeQueueSel, .readQueueSel,
    .trafficEnable, .configDone, .cfgActive, .almostEmptyOffset, .almostFullOffset,
    .ptrClearPulse, .ptrClearQueue, .queueEmpty);
`default_nettype wire

// *** testbench/mq_host_model.sv ***
// Purpose: Host side driving reset pins, straps and queue selects
// Assumes: Pins change just after rising clk
// Notes: Straps show their inverse once master reset is over
`timescale 1ns/1ps
`default_nettype none
module mq_host_model
    import mq_reset_pkg::*;
(
    input wire logic clk,
    output logic masterResetN,
    output logic queuePointerClearN,
    output strap_cfg_t straps,
    output logic [4:0] writeQueueSel,
    output logic [4:0] readQueueSel,
    output logic writeEnable
);
    initial begin
        masterResetN = 1'b0;
        queuePointerClearN = 1'b1;
        straps = STRAP_RESET;
        writeQueueSel = '0;
        readQueueSel = '0;
        writeEnable = 1'b0;
    end
    task mreset(input strap_cfg_t c, input int n);
        @(posedge clk);
        masterResetN <= 1'b0;
        straps <= c;
        repeat (n) @(posedge clk);
        masterResetN <= 1'b1;
        @(posedge clk);
        straps <= ~c;
    endtask
    task write(input logic [4:0] q);
        @(posedge clk);
        writeQueueSel <= q;
        writeEnable <= 1'b1;
        @(posedge clk);
        writeEnable <= 1'b0;
    endtask
    task pclear(input logic [4:0] q);
        @(posedge clk);
        writeQueueSel <= q;
        readQueueSel <= q;
        repeat (3) @(posedge clk);
        queuePointerClearN <= 1'b0;
        @(posedge clk);
        queuePointerClearN <= 1'b1;
    endtask
endmodule
`default_nettype wire

// *** testbench/tb_multi_queue_reset_control.sv ***
// Purpose: Directed bench for master and partial reset
// Assumes: AHB-Lite master tasks, host model on the pins
// Notes: LOAD_CYCLES shortened to 4
`timescale 1ns/1ps
`default_nettype none
module tb_multi_queue_reset_control
    import mq_reset_pkg::*;
;
    logic clk, nrst, hsel, hwrite, hreadyout, hresp, masterResetN, queuePointerClearN;
    logic writeEnable, trafficEnable, configDone, ptrClearPulse;
    logic [31:0] haddr, hwdata, hrdata, rd, queueEmpty;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [4:0] writeQueueSel, readQueueSel, ptrClearQueue;
    logic [15:0] almostEmptyOffset, almostFullOffset;
    strap_cfg_t straps, cfgActive;
    int bad_count, cmp_count;
    mq_reset_control #(.NUM_QUEUES(32), .LOAD_CYCLES(4)) dut (.clk, .nrst, .hsel, .haddr,
        .htrans, .hwrite, .hsize, .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp,
        .masterResetN, .queuePointerClearN, .straps, .writeQueueSel, .readQueueSel,
        .writeEnable, .trafficEnable, .configDone, .cfgActive, .almostEmptyOffset,
        .almostFullOffset, .ptrClearPulse, .ptrClearQueue, .queueEmpty);
    mq_host_model host (.clk, .masterResetN, .queuePointerClearN, .straps, .writeQueueSel,
        .readQueueSel, .writeEnable);
    ////////////////////////////////////////////////////////////////
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= 3'h2;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= HTRANS_IDLE;
        hsize <= 3'h0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task rdchk(input string n, input logic [7:0] a, input logic [31:0] exp);
        ahb(1'b0, a, '0);
        chk(n, rd, exp);
    endtask
    task waitDone;
        for (int i = 0; i < 100 && configDone !== 1'b1; i++) @(posedge clk);
    endtask
    task tdef(input strap_cfg_t c, input logic [31:0] off);
        host.mreset(c, 8);
        waitDone();
        rdchk("straps", ADDR_STRAPS, 32'(c));
        rdchk("offset", ADDR_OFFSET, off);
        ahb(1'b1, ADDR_OFFSET, 32'h0011_0022);
        rdchk("offset refused", ADDR_OFFSET, off);
        rdchk("status", ADDR_STATUS, 32'h0000_001F);
        $display("test default done");
    endtask
    task stop_test;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        #40000;
        bad_count++;
        stop_test();
    end
    initial begin
        nrst = 1'b0;
        hsel = 1'b0;
        haddr = '0;
        htrans = HTRANS_IDLE;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = '0;
        bad_count = 0;
        cmp_count = 0;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        tdef(strap_cfg_t'(11'h436), 32'h0008_0008);
        tdef(strap_cfg_t'(11'h3CB), 32'h0080_0080);
        host.mreset(strap_cfg_t'(11'h01D), 3);
        rdchk("status serial", ADDR_STATUS, 32'h0000_0001);
        rdchk("offset reset", ADDR_OFFSET, '0);
        host.write(5'h03);
        rdchk("empty blocked", ADDR_EMPTY, 32'hFFFF_FFFF);
        ahb(1'b1, ADDR_OFFSET, 32'h0030_0040);
        rdchk("offset serial", ADDR_OFFSET, 32'h0030_0040);
        ahb(1'b1, ADDR_CTRL, 32'h0000_0001);
        waitDone();
        rdchk("status ready", ADDR_STATUS, 32'h0000_0017);
        host.write(5'h05);
        host.write(5'h09);
        rdchk("empty written", ADDR_EMPTY, 32'hFFFF_FDDF);
        host.pclear(5'h05);
        repeat (3) @(posedge clk);
        rdchk("empty cleared", ADDR_EMPTY, 32'hFFFF_FDFF);
        chk("hresp", {31'h0000_0000, hresp}, 32'h0000_0000);
        chk("clear queue", {27'h000_0000, ptrClearQueue}, 32'h0000_0005);
        rdchk("offset kept", ADDR_OFFSET, 32'h0030_0040);
        rdchk("straps kept", ADDR_STRAPS, 32'h0000_001D);
        rdchk("unmapped", 8'h40, RDATA_ZERO);
        host.mreset(strap_cfg_t'(11'h01D), 3);
        rdchk("empty mreset", ADDR_EMPTY, 32'hFFFF_FFFF);
        rdchk("offset mreset", ADDR_OFFSET, '0);
        $display("test serial done");
        stop_test();
    end
endmodule
`default_nettype wire
